// [src/alarm_params.svh]
// alarm_params.svh: constants shared by the dual alarm comparator.
// assumes a 100 MHz system clock and BCD-coded rate and total values.
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH

`define CLK_PERIOD_NS     10
`define SAMPLE_PERIOD_MS  500
`define SAMPLE_CYCLES     ((`SAMPLE_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define SECOND_SAMPLES    2
`define IDLE_TIMEOUT_S    10
`define DELAY_MAX_S       3600
`define RATE_DIGITS       6
`define TOTAL_DIGITS      8
`define CODE_DIGITS       4
`define DIGIT_MAX         4'h9
`define FLASH_SAMPLES     1
`define DEF_SETPOINT      32'h00000000
`define DEF_BAND          24'h000000
`define DEF_WAIT          16'h0000
`define DEF_SILENCE       16'h0000
`define DEF_CODE          16'h0000

`endif

// [src/alarm_pkg.sv]
// alarm_pkg.sv: types for the dual alarm comparator.
// assumes alarm_params.svh is available on the include path.
package alarm_pkg;
    typedef enum logic [2:0] {
        MENU_DISPLAY,
        MENU_CODE_PROMPT,
        MENU_CODE_EDIT,
        MENU_SP_PROMPT,
        MENU_SP_EDIT
    } menu_state_t;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_WAIT,
        CH_ACTIVE,
        CH_SILENCED
    } chan_state_t;
endpackage

// [src/alarm_channel.sv]
// alarm_channel.sv: one alarm channel, comparison, hysteresis, delay and silence.
// assumes values are BCD, sampled on tick_in (twice a second), sec_in once a second.
`include "alarm_params.svh"
`timescale 1ns/100ps
`default_nettype none

module alarm_channel (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // timing
    input  wire logic        tick_in,
    input  wire logic        sec_in,
    // value and configuration
    input  wire logic [31:0] value_in,
    input  wire logic        enable_in,
    input  wire logic        src_total_in,
    input  wire logic [31:0] setpoint_in,
    input  wire logic        high_in,
    input  wire logic        norm_closed_in,
    input  wire logic [23:0] band_in,
    input  wire logic [15:0] wait_in,
    input  wire logic [15:0] silence_in,
    input  wire logic        accept_in,
    // results
    output logic             cond_out,
    output logic             switch_out,
    output logic             lamp_on_out,
    output logic             lamp_blink_out,
    output logic             active_out
);
    alarm_pkg::chan_state_t state_reg;
    logic                   cond_reg;
    logic [15:0]            count_reg;
    logic [31:0]            band_w;
    logic [31:0]            trip_hi;
    logic [31:0]            rel_hi;
    logic                   cond_next;

    // BCD add/subtract is avoided by comparing binary of the BCD-coded digits
    function automatic logic [31:0] to_bin(input logic [31:0] b);
        logic [31:0] r;
        r = 32'h00000000;
        for (int i = 7; i >= 0; i--)
        begin
            r = (r * 32'd10) + {28'h0000000, b[i*4 +: 4]};
        end
        return r;
    endfunction

    assign band_w  = src_total_in ? 32'h00000000 : to_bin({8'h00, band_in});
    assign trip_hi = to_bin(setpoint_in);
    assign rel_hi  = to_bin(value_in);

    always_comb
    begin
        cond_next = cond_reg;
        if (high_in)
        begin
            if (rel_hi >= trip_hi)
                cond_next = 1'b1;
            else if (rel_hi + band_w < trip_hi)
                cond_next = 1'b0;
        end
        else
        begin
            if (rel_hi <= trip_hi)
                cond_next = 1'b1;
            else if (rel_hi > trip_hi + band_w)
                cond_next = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            cond_reg <= 1'b0;
        else if (!enable_in)
            cond_reg <= 1'b0;
        else if (tick_in)
            cond_reg <= cond_next;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= alarm_pkg::CH_IDLE;
            count_reg <= `DEF_WAIT;
        end
        else if (!cond_reg)
        begin
            state_reg <= alarm_pkg::CH_IDLE;
            count_reg <= `DEF_WAIT;
        end
        else
        begin
            case (state_reg)
                alarm_pkg::CH_IDLE:
                begin
                    state_reg <= (wait_in == `DEF_WAIT) ? alarm_pkg::CH_ACTIVE
                                                         : alarm_pkg::CH_WAIT;
                    count_reg <= wait_in;
                end
                alarm_pkg::CH_WAIT:
                begin
                    if (sec_in)
                    begin
                        if (count_reg <= 16'h0001)
                            state_reg <= alarm_pkg::CH_ACTIVE;
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                alarm_pkg::CH_ACTIVE:
                begin
                    if (accept_in && (silence_in != `DEF_SILENCE))
                    begin
                        state_reg <= alarm_pkg::CH_SILENCED;
                        count_reg <= silence_in;
                    end
                end
                alarm_pkg::CH_SILENCED:
                begin
                    if (sec_in)
                    begin
                        if (count_reg <= 16'h0001)
                            state_reg <= alarm_pkg::CH_ACTIVE;
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                default:
                    state_reg <= alarm_pkg::CH_IDLE;
            endcase
        end
    end

    assign cond_out       = cond_reg;
    assign active_out     = (state_reg == alarm_pkg::CH_ACTIVE);
    assign switch_out     = active_out ^ norm_closed_in;
    assign lamp_on_out    = active_out;
    assign lamp_blink_out = (state_reg == alarm_pkg::CH_WAIT) ||
                            (state_reg == alarm_pkg::CH_SILENCED);

    a_wait_zero_direct: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == alarm_pkg::CH_IDLE && cond_reg && wait_in == 16'h0000)
        |=> active_out)
        else $error("zero delay did not activate output at once");
    a_silence_needs_time: assert property (@(posedge clk_in) disable iff (rst_in)
        (active_out && accept_in && silence_in == 16'h0000 && cond_reg) |=> active_out)
        else $error("accept acted with zero silence time");
    a_output_sense: assert property (@(posedge clk_in) disable iff (rst_in)
        !cond_reg |=> (switch_out == norm_closed_in))
        else $error("output not at rest state without alarm");
    a_disable_clears: assert property (@(posedge clk_in) disable iff (rst_in)
        !enable_in |=> !cond_reg)
        else $error("disabled channel kept its condition");
endmodule

`default_nettype wire

// [src/dual_alarm_comparator.sv]
// dual_alarm_comparator.sv: two alarm channels plus the operator setpoint menu.
// assumes button inputs are single-cycle presses, synchronous to CLK_IN.
// How it works
// - two channels, each with its own full set of settings
// - enable switches a channel on or off, other settings kept
// - each channel picks rate or total as its source
// - changing the source resets the channel setpoint and disables it
// - rate setpoint six BCD digits, total setpoint eight BCD digits
// - alarm trips when value reaches the setpoint in the chosen direction
// - each channel independently high or low
// - polarity setting gives the resting switch state, alarm inverts it
// - hysteresis only used on rate alarms
// - high rate alarm holds until rate drops below setpoint minus band
// - per-channel activation delay in seconds, up to 3600, zero means none
// - annunciator flashes during delay, then steady with output on
// - P accepts alarms only when silence time is nonzero
// - accept silences output for silence time, annunciator flashes meanwhile
// - flash option alternates display with the channel identifier
// - setpoint menu from display by P and up together, code guarded
// - digit-wise edit: up/down change digit, P next, E stores
// - new access code active on return to display; zero code skips check
// - values sampled and compared twice a second
// - wrong code or ten idle seconds return to display
`include "alarm_params.svh"
`timescale 1ns/100ps
`default_nettype none

module dual_alarm_comparator (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    // process values, BCD
    input  wire logic [23:0] RATE_VALUE_IN,
    input  wire logic [31:0] TOTAL_VALUE_IN,
    // configuration, per channel index 0 = first_alarm, 1 = second_alarm
    input  wire logic [1:0]  ENABLE_IN,
    input  wire logic [1:0]  ALARM_SOURCE_SELECT_IN,
    input  wire logic [1:0]  TRIP_DIRECTION_IN,
    input  wire logic [1:0]  NORM_CLOSED_IN,
    input  wire logic [1:0]  BLINK_ON_TRIP_IN,
    input  wire logic [47:0] RELEASE_BAND_IN,
    input  wire logic [31:0] ACTIVATION_WAIT_IN,
    input  wire logic [31:0] SILENCE_TIME_IN,
    input  wire logic [63:0] CFG_TRIP_VALUE_IN,
    input  wire logic [1:0]  CFG_TRIP_LOAD_IN,
    input  wire logic        DIRECT_SETPOINT_MENU_IN,
    input  wire logic [15:0] SETPOINT_ACCESS_CODE_IN,
    // front-panel buttons
    input  wire logic        BTN_P_IN,
    input  wire logic        BTN_E_IN,
    input  wire logic        BTN_UP_IN,
    input  wire logic        BTN_DOWN_IN,
    // alarm outputs and annunciators
    output logic [1:0]       SWITCH_CLOSED_OUT,
    output logic [1:0]       LAMP_ON_OUT,
    output logic [1:0]       LAMP_BLINK_OUT,
    output logic [1:0]       CHANNEL_ENABLED_OUT,
    // display control
    output logic [1:0]       SHOW_ALARM_ID_OUT,
    output logic [2:0]       MENU_STATE_OUT,
    output logic             MENU_CHANNEL_OUT,
    output logic [2:0]       EDIT_DIGIT_OUT,
    output logic [31:0]      EDIT_VALUE_OUT,
    output logic [63:0]      FIRST_ALARM_TRIP_VALUE_OUT
);
    logic [31:0]            tick_cnt_reg;
    logic                   tick;
    logic                   half_reg;
    logic                   sec;
    logic [1:0]             src_reg;
    logic [31:0]            sp_reg [2];
    logic [15:0]            code_reg;
    alarm_pkg::menu_state_t menu_reg;
    logic                   mch_reg;
    logic [2:0]             dig_reg;
    logic [31:0]            ed_reg;
    logic [4:0]             idle_reg;
    logic                   any_btn;
    logic                   in_menu;
    logic [1:0]             active_w;
    logic [1:0]             flash_reg;
    logic [3:0]             ndig;

    // half-second sampling tick; one-second strobe every second tick
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            tick_cnt_reg <= 32'h00000000;
        else if (tick)
            tick_cnt_reg <= 32'h00000000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
    assign tick = (tick_cnt_reg == 32'(`SAMPLE_CYCLES - 1));

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            half_reg <= 1'b0;
        else if (tick)
            half_reg <= ~half_reg;
    end
    assign sec = tick & half_reg;

    // last source seen, so that a change shows up as a one-cycle mismatch
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            src_reg <= 2'h0;
        else
            src_reg <= ALARM_SOURCE_SELECT_IN;
    end
    // enable re-arms only on a fresh rising of the enable setting after a source change
    logic [1:0] en_prev_reg;
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            en_prev_reg <= 2'h0;
        else
            en_prev_reg <= ENABLE_IN;
    end
    logic [1:0] armed_reg;
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            armed_reg <= 2'h0;
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (ALARM_SOURCE_SELECT_IN[c] != src_reg[c])
                    armed_reg[c] <= 1'b0;
                else if (ENABLE_IN[c] && !en_prev_reg[c])
                    armed_reg[c] <= 1'b1;
                else if (!ENABLE_IN[c])
                    armed_reg[c] <= 1'b0;
            end
        end
    end

    // setpoint storage: configuration load or operator menu store
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            sp_reg[0] <= `DEF_SETPOINT;
            sp_reg[1] <= `DEF_SETPOINT;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (ALARM_SOURCE_SELECT_IN[c] != src_reg[c])
                    sp_reg[c] <= `DEF_SETPOINT;
                else if (CFG_TRIP_LOAD_IN[c])
                    sp_reg[c] <= ALARM_SOURCE_SELECT_IN[c] ? CFG_TRIP_VALUE_IN[c*32 +: 32]
                               : {8'h00, CFG_TRIP_VALUE_IN[c*32 +: 24]};
                else if (menu_reg == alarm_pkg::MENU_SP_EDIT && BTN_E_IN && mch_reg == c[0])
                    sp_reg[c] <= ed_reg;
            end
        end
    end

    // access code is latched only while in display mode
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            code_reg <= `DEF_CODE;
        else if (menu_reg == alarm_pkg::MENU_DISPLAY)
            code_reg <= SETPOINT_ACCESS_CODE_IN;
    end

    assign any_btn = BTN_P_IN | BTN_E_IN | BTN_UP_IN | BTN_DOWN_IN;
    assign in_menu = (menu_reg != alarm_pkg::MENU_DISPLAY);
    // one bit wider than the digit index so eight digits need no overflow trick
    assign ndig    = (menu_reg == alarm_pkg::MENU_CODE_EDIT) ? 4'(`CODE_DIGITS)
                   : (ALARM_SOURCE_SELECT_IN[mch_reg] ? 4'(`TOTAL_DIGITS)
                                                      : 4'(`RATE_DIGITS));

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            idle_reg <= 5'h00;
        else if (!in_menu || any_btn)
            idle_reg <= 5'h00;
        else if (tick)
            idle_reg <= idle_reg + 5'h01;
    end

    // operator setpoint menu
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            menu_reg <= alarm_pkg::MENU_DISPLAY;
            mch_reg  <= 1'b0;
            dig_reg  <= 3'h0;
            ed_reg   <= 32'h00000000;
        end
        else if (in_menu && idle_reg == 5'(`IDLE_TIMEOUT_S * `SECOND_SAMPLES))
            menu_reg <= alarm_pkg::MENU_DISPLAY;
        else
        begin
            case (menu_reg)
                alarm_pkg::MENU_DISPLAY:
                    if (DIRECT_SETPOINT_MENU_IN && BTN_P_IN && BTN_UP_IN)
                    begin
                        mch_reg  <= 1'b0;
                        menu_reg <= (code_reg == `DEF_CODE) ? alarm_pkg::MENU_SP_PROMPT
                                                            : alarm_pkg::MENU_CODE_PROMPT;
                    end
                alarm_pkg::MENU_CODE_PROMPT:
                    if (BTN_P_IN)
                    begin
                        menu_reg <= alarm_pkg::MENU_CODE_EDIT;
                        ed_reg   <= 32'h00000000;
                        dig_reg  <= 3'h0;
                    end
                alarm_pkg::MENU_CODE_EDIT, alarm_pkg::MENU_SP_EDIT:
                begin
                    if (BTN_E_IN)
                    begin
                        if (menu_reg == alarm_pkg::MENU_SP_EDIT)
                            menu_reg <= alarm_pkg::MENU_SP_PROMPT;
                        else if (ed_reg[15:0] == code_reg)
                            menu_reg <= alarm_pkg::MENU_SP_PROMPT;
                        else
                            menu_reg <= alarm_pkg::MENU_DISPLAY;
                    end
                    else if (BTN_P_IN)
                        dig_reg <= ({1'b0, dig_reg} + 4'h1 == ndig) ? 3'h0
                                                                    : dig_reg + 3'h1;
                    else if (BTN_UP_IN)
                        ed_reg[dig_reg*4 +: 4] <= (ed_reg[dig_reg*4 +: 4] == `DIGIT_MAX)
                            ? 4'h0 : ed_reg[dig_reg*4 +: 4] + 4'h1;
                    else if (BTN_DOWN_IN)
                        ed_reg[dig_reg*4 +: 4] <= (ed_reg[dig_reg*4 +: 4] == 4'h0)
                            ? `DIGIT_MAX : ed_reg[dig_reg*4 +: 4] - 4'h1;
                end
                alarm_pkg::MENU_SP_PROMPT:
                    if (BTN_UP_IN || BTN_DOWN_IN)
                        mch_reg <= ~mch_reg;
                    else if (BTN_P_IN)
                    begin
                        menu_reg <= alarm_pkg::MENU_SP_EDIT;
                        ed_reg   <= sp_reg[mch_reg];
                        dig_reg  <= 3'h0;
                    end
                    else if (BTN_E_IN)
                        menu_reg <= alarm_pkg::MENU_DISPLAY;
                default:
                    menu_reg <= alarm_pkg::MENU_DISPLAY;
            endcase
        end
    end

    // two identical channels
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        alarm_channel u_ch (
            .clk_in         (CLK_IN),
            .rst_in         (SYS_RST_IN),
            .tick_in        (tick),
            .sec_in         (sec),
            .value_in       (src_reg[c] ? TOTAL_VALUE_IN : {8'h00, RATE_VALUE_IN}),
            .enable_in      (armed_reg[c]),
            .src_total_in   (src_reg[c]),
            .setpoint_in    (sp_reg[c]),
            .high_in        (TRIP_DIRECTION_IN[c]),
            .norm_closed_in (NORM_CLOSED_IN[c]),
            .band_in        (RELEASE_BAND_IN[c*24 +: 24]),
            .wait_in        ((ACTIVATION_WAIT_IN[c*16 +: 16] > 16'(`DELAY_MAX_S))
                             ? 16'(`DELAY_MAX_S) : ACTIVATION_WAIT_IN[c*16 +: 16]),
            .silence_in     (SILENCE_TIME_IN[c*16 +: 16]),
            .accept_in      (BTN_P_IN && !in_menu),
            .cond_out       (),
            .switch_out     (SWITCH_CLOSED_OUT[c]),
            .lamp_on_out    (LAMP_ON_OUT[c]),
            .lamp_blink_out (LAMP_BLINK_OUT[c]),
            .active_out     (active_w[c])
        );
    end

    // display alternation toggles each sample period while output active
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            flash_reg <= 2'h0;
        else
            for (int c = 0; c < 2; c++)
                flash_reg[c] <= (active_w[c] && BLINK_ON_TRIP_IN[c])
                              ? (tick ? ~flash_reg[c] : flash_reg[c]) : 1'b0;
    end

    assign SHOW_ALARM_ID_OUT          = flash_reg;
    assign CHANNEL_ENABLED_OUT        = armed_reg;
    assign MENU_STATE_OUT             = menu_reg;
    assign MENU_CHANNEL_OUT           = mch_reg;
    assign EDIT_DIGIT_OUT             = dig_reg;
    assign EDIT_VALUE_OUT             = ed_reg;
    assign FIRST_ALARM_TRIP_VALUE_OUT = {sp_reg[1], sp_reg[0]};

    sequence s_code_wrong;
        menu_reg == alarm_pkg::MENU_CODE_EDIT && BTN_E_IN && ed_reg[15:0] != code_reg;
    endsequence
    a_wrong_code_exit: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_code_wrong |=> menu_reg == alarm_pkg::MENU_DISPLAY)
        else $error("wrong code did not return to display");
    a_src_change_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (ALARM_SOURCE_SELECT_IN[0] != src_reg[0]) |=> !armed_reg[0] && sp_reg[0] == 32'h0)
        else $error("source change did not reset channel");
    a_zero_code_skip: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (menu_reg == alarm_pkg::MENU_DISPLAY && DIRECT_SETPOINT_MENU_IN && BTN_P_IN
         && BTN_UP_IN && code_reg == 16'h0) |=> menu_reg == alarm_pkg::MENU_SP_PROMPT)
        else $error("zero code still asked for code");
    a_menu_disabled: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (menu_reg == alarm_pkg::MENU_DISPLAY && !DIRECT_SETPOINT_MENU_IN) |=> !in_menu)
        else $error("menu entered while access disabled");

    // an operator store into the first channel lands exactly as edited
    sequence s_store_first;
        menu_reg == alarm_pkg::MENU_SP_EDIT && BTN_E_IN && !mch_reg && !CFG_TRIP_LOAD_IN[0]
        && ALARM_SOURCE_SELECT_IN[0] == src_reg[0];
    endsequence
    a_store_first_sp: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_store_first |=> sp_reg[0] == $past(ed_reg))
        else $error("edited setpoint not stored");
    a_code_held_menu: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        in_menu |=> $stable(code_reg))
        else $error("access code changed inside the menu");
    a_idle_return: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (in_menu && idle_reg == 5'(`IDLE_TIMEOUT_S * `SECOND_SAMPLES)) |=> !in_menu)
        else $error("idle menu did not return to display");
    a_arm_on_rise: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (ENABLE_IN[1] && !en_prev_reg[1] && ALARM_SOURCE_SELECT_IN[1] == src_reg[1])
        |=> armed_reg[1])
        else $error("enable rise did not arm the channel");
    a_enable_low_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        !ENABLE_IN[0] |=> !armed_reg[0])
        else $error("channel armed with enable low");
endmodule

`default_nettype wire

// [dv/panel_operator.sv]
// panel_operator.sv: operator front-panel model, presses buttons.
// assumes tb calls push() between clock edges; one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module panel_operator (
    input  wire logic clk_in,
    output logic      p_out,
    output logic      e_out,
    output logic      up_out,
    output logic      down_out
);
    initial {p_out, e_out, up_out, down_out} = 4'h0;
    // mask {p,e,up,down}; gap lets the menu settle before the next press
    task automatic push(input logic [3:0] m);
        @(posedge clk_in);
        {p_out, e_out, up_out, down_out} <= m;
        @(posedge clk_in);
        {p_out, e_out, up_out, down_out} <= 4'h0;
        repeat (3) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// tb.sv: bench for the dual alarm comparator, config and setpoint menu.
// assumes the 0.5 s tick is too slow to reach; alarm timing left to design assertions.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, menu_on = 1'b0;
    logic [1:0] en = 2'h0, src = 2'h0, dir = 2'h1, nc = 2'h2, blink = 2'h3, load = 2'h0;
    logic [63:0] trip = 64'h0, tv;
    logic [15:0] code = 16'h0;
    logic [23:0] rate = 24'h000100;
    logic [31:0] total = 32'h00000200, wt = 32'h00020001, sil = 32'h00010000;
    logic [47:0] band = 48'h000010000010;
    logic p, e, up, dn;
    logic [1:0] sw, lon, lbl, ena, sid;
    logic [2:0] ms, dig;
    logic mch;
    logic [31:0] ev;
    int bad_count = 0, samples_checked = 0;
    initial forever #5 clk = ~clk;
    panel_operator u_op (.clk_in(clk), .p_out(p), .e_out(e), .up_out(up), .down_out(dn));
    dual_alarm_comparator u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .RATE_VALUE_IN(rate),
        .TOTAL_VALUE_IN(total), .ENABLE_IN(en), .ALARM_SOURCE_SELECT_IN(src),
        .TRIP_DIRECTION_IN(dir), .NORM_CLOSED_IN(nc), .BLINK_ON_TRIP_IN(blink),
        .RELEASE_BAND_IN(band), .ACTIVATION_WAIT_IN(wt),
        .SILENCE_TIME_IN(sil), .CFG_TRIP_VALUE_IN(trip), .CFG_TRIP_LOAD_IN(load),
        .DIRECT_SETPOINT_MENU_IN(menu_on), .SETPOINT_ACCESS_CODE_IN(code), .BTN_P_IN(p),
        .BTN_E_IN(e), .BTN_UP_IN(up), .BTN_DOWN_IN(dn), .SWITCH_CLOSED_OUT(sw),
        .LAMP_ON_OUT(lon), .LAMP_BLINK_OUT(lbl), .CHANNEL_ENABLED_OUT(ena),
        .SHOW_ALARM_ID_OUT(sid), .MENU_STATE_OUT(ms), .MENU_CHANNEL_OUT(mch),
        .EDIT_DIGIT_OUT(dig), .EDIT_VALUE_OUT(ev), .FIRST_ALARM_TRIP_VALUE_OUT(tv));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_reset();
        chk({sw, lon, lbl, ena, ms}, {2'h2, 6'h0, 3'h0});
        chk({sid, mch, dig, ev}, 64'h0);
        @(posedge clk) nc <= 2'h1;
        @(posedge clk) #1 chk(64'(sw), 64'h1);
        $display("test reset done");
    endtask
    task automatic t_config();
        @(posedge clk)
        begin
            en <= 2'h1;
            {rate, total, band} <= {24'h999999, 32'h99999999, 48'h000050000050};
            {dir, blink, wt, sil} <= {2'h2, 2'h0, 32'h00000000, 32'h00050005};
        end
        repeat (3) @(posedge clk);
        #1 chk(64'(ena), 64'h1);
        chk({lon, lbl, sid}, 64'h0);
        @(posedge clk) src <= 2'h1;
        repeat (3) @(posedge clk);
        #1 chk(64'(ena), 64'h0);
        chk(tv, 64'h0);
        @(posedge clk) {trip, load} <= {64'h9999999912345678, 2'h1};
        @(posedge clk) load <= 2'h0;
        repeat (2) @(posedge clk);
        #1 chk(tv, 64'h0000000012345678);
        @(posedge clk) en <= 2'h0;
        @(posedge clk) en <= 2'h1;
        repeat (3) @(posedge clk);
        #1 chk(64'(ena), 64'h1);
        $display("test config done");
    endtask
    // code zero: straight to the setpoint prompt, then a digit-wise edit
    task automatic t_edit();
        @(posedge clk) menu_on <= 1'b1;
        u_op.push(4'ha);
        #1 chk(64'(ms), 64'(alarm_pkg::MENU_SP_PROMPT));
        u_op.push(4'h8);
        u_op.push(4'h2);
        u_op.push(4'h2);
        #1 chk(64'(ev), 64'h12345670);
        u_op.push(4'h8);
        #1 chk(64'(dig), 64'h1);
        u_op.push(4'h1);
        u_op.push(4'h4);
        #1 chk(tv, 64'h0000000012345660);
        u_op.push(4'h4);
        #1 chk(64'(ms), 64'(alarm_pkg::MENU_DISPLAY));
        $display("test edit done");
    endtask
    task automatic t_code();
        @(posedge clk) code <= 16'h0042;
        repeat (2) @(posedge clk);
        u_op.push(4'ha);
        #1 chk(64'(ms), 64'(alarm_pkg::MENU_CODE_PROMPT));
        u_op.push(4'h8);
        u_op.push(4'h4);
        #1 chk(64'(ms), 64'(alarm_pkg::MENU_DISPLAY));
        u_op.push(4'ha);
        u_op.push(4'h8);
        u_op.push(4'h2);
        u_op.push(4'h2);
        u_op.push(4'h8);
        repeat (4) u_op.push(4'h2);
        u_op.push(4'h4);
        #1 chk(64'(ms), 64'(alarm_pkg::MENU_SP_PROMPT));
        u_op.push(4'h2);
        #1 chk(64'(mch), 64'h1);
        u_op.push(4'h8);
        #1 chk(64'(ev), 64'h0);
        u_op.push(4'h4);
        u_op.push(4'h4);
        @(posedge clk) menu_on <= 1'b0;
        u_op.push(4'ha);
        #1 chk(64'(ms), 64'(alarm_pkg::MENU_DISPLAY));
        $display("test code done");
    endtask
    // reset again mid-run: the source mismatch after release must leave ch0 disarmed
    task automatic t_rerun();
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({ms, ena, tv[31:0]}, 64'h0);
        chk(64'(sw), 64'h1);
        $display("test rerun done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        t_reset();
        t_config();
        t_edit();
        t_code();
        t_rerun();
        give_verdict();
    end
    initial
    begin
        #(20000 * 10);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
